//--- core/gtm_pkg.sv
// Purpose: Shared constants and types of the general timer block.
// Assumes: 32-bit register word, byte offsets on the plain register port.
// Notes:   Offsets and bit positions are local to this block.
package gtm_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CONFIG   = 8'h00;
    localparam logic [7:0] OFF_LO_MODE  = 8'h04;
    localparam logic [7:0] OFF_HI_MODE  = 8'h08;
    localparam logic [7:0] OFF_CONTROL  = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_IRQ_RAW  = 8'h1C;
    localparam logic [7:0] OFF_IRQ_MSK  = 8'h20;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h24;
    localparam logic [7:0] OFF_LO_LOAD  = 8'h28;
    localparam logic [7:0] OFF_HI_LOAD  = 8'h2C;
    localparam logic [7:0] OFF_LO_MATCH = 8'h30;
    localparam logic [7:0] OFF_LO_PRE   = 8'h38;
    localparam logic [7:0] OFF_HI_PRE   = 8'h3C;
    localparam logic [7:0] OFF_LO_COUNT = 8'h48;
    localparam logic [7:0] OFF_HI_COUNT = 8'h4C;

    // Configuration values.
    localparam logic [2:0] CFG_32_TIMER = 3'h0;
    localparam logic [2:0] CFG_32_RTC   = 3'h1;
    localparam logic [2:0] CFG_16_SPLIT = 3'h4;

    // Mode field values.
    localparam logic [1:0] MODE_ONESHOT  = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;

    // Control register bit positions.
    localparam int CTL_LO_EN    = 0;
    localparam int CTL_LO_STALL = 1;
    localparam int CTL_RTC_EN   = 4;
    localparam int CTL_LO_ADC   = 5;
    localparam int CTL_HI_EN    = 8;
    localparam int CTL_HI_STALL = 9;
    localparam int CTL_HI_ADC   = 13;

    // Status bit positions.
    localparam int RIS_TO_LO = 0;
    localparam int RIS_RTC   = 3;
    localparam int RIS_TO_HI = 8;

    // Values after reset, and the RTC seed loaded on first selection.
    localparam logic [15:0] CNT_RST  = 16'hFFFF;
    localparam logic [7:0]  PRE_RST  = 8'h00;
    localparam logic [31:0] RTC_SEED = 32'h0000_0001;

    // Real-time clock input rate and tick rate, in Hz.
    localparam int RTC_CLK_HZ  = 32768;
    localparam int RTC_TICK_HZ = 1;
    localparam int RTC_DIV_DEF = RTC_CLK_HZ / RTC_TICK_HZ;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } gtm_bus_req_s;
endpackage

//--- core/gtm_timer.sv
// Purpose: General timer block, two 16-bit halves joined for 32-bit modes.
// Assumes: Debug halt comes from logic on the same clock; the RTC input
//          pin is asynchronous.
// Notes:   Prescalers are stored but not used; 16-bit capture and PWM
//          modes are not built.
//
// Notes on behaviour
// R1: Two 16-bit counters, usable apart or joined as 32-bit timer or RTC.
// R2: Trigger outputs of all timer blocks are ORed before the converter.
// R3: Reset leaves block idle, counters and loads 0xFFFF, prescales 0x00.
// R4: Config 0 selects 32-bit timer, config 1 selects 32-bit RTC.
// R5: In 16-bit operation each half runs on its own settings.
// R6: In 32-bit modes a low load write fills both load halves.
// R7: In 32-bit modes a low count read returns high:low counters.
// R8: In 32-bit modes one-shot or periodic comes only from the low mode field.
// R9: Low enable starts down count; at zero the load reloads next cycle.
// R10: One-shot stops and clears enable at reload; periodic keeps going.
// R11: Zero sets low timeout raw status, held until cleared by software.
// R12: Masked timeout status follows raw status when the mask allows.
// R13: Converter trigger at zero only while its enable bit is set.
// R14: A load write while running is taken as the count next cycle.
// R15: With stall bit set, counting freezes during debug halt.
// R16: RTC counts up, seeded with one on first selection.
// R17: The outside source drives 32.768 kHz on the even capture pin.
// R18: RTC input is divided to a 1 Hz tick advancing the counter.
// R19: On match the RTC count wraps to zero and keeps counting.
// R20: Match sets RTC raw status; unmasked it sets masked and interrupt.
// R21: Writing the RTC clear bit clears raw and masked RTC status.
// R22: With RTC enable set, debug halt never freezes the counter.
// R23: Config 4 selects 16-bit operation with separate halves.
// R24: Masked status is raw AND mask; interrupt is OR of masked.
// R25: RTC input is synchronised and edge detected in the system clock.
`timescale 1ns/100ps
module gtm_timer #(
    parameter int RTC_DIV = gtm_pkg::RTC_DIV_DEF,
    parameter int DIV_W   = 16
) (
    // Clock and reset.
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // Register port.
    input  wire gtm_pkg::gtm_bus_req_s bus_req,
    output logic [31:0]               rdata,
    // Pins and system signals.
    input  wire logic                 capture_pin_0,
    input  wire logic                 dbg_halt,
    input  wire logic                 adc_trigger_in,
    output logic                      adc_trigger_out,
    output logic                      irq_out
);
    import gtm_pkg::*;

    logic [2:0]       cfg_q;
    logic [1:0]       lo_mode_q;
    logic [1:0]       hi_mode_q;
    logic [15:0]      ctl_q;
    logic [15:0]      ctl_d;
    logic [15:0]      imr_q;
    logic [15:0]      ris_q;
    logic [15:0]      ris_d;
    logic [15:0]      load_lo_q;
    logic [15:0]      load_hi_q;
    logic [7:0]       pre_lo_q;
    logic [7:0]       pre_hi_q;
    logic [31:0]      match_q;
    logic [15:0]      cnt_lo_q;
    logic [15:0]      cnt_hi_q;
    logic [31:0]      cnt_d;
    logic             rtc_seen_q;
    logic             adc_q;
    logic [31:0]      rd_val;
    logic             cap_s1_q;
    logic             cap_s2_q;
    logic             cap_s3_q;
    logic [DIV_W-1:0] div_q;

    // Write decode.
    wire wr_cfg     = bus_req.wr && bus_req.addr == OFF_CONFIG;
    wire wr_lo_mode = bus_req.wr && bus_req.addr == OFF_LO_MODE;
    wire wr_hi_mode = bus_req.wr && bus_req.addr == OFF_HI_MODE;
    wire wr_ctl     = bus_req.wr && bus_req.addr == OFF_CONTROL;
    wire wr_imr     = bus_req.wr && bus_req.addr == OFF_IRQ_MASK;
    wire wr_icr     = bus_req.wr && bus_req.addr == OFF_IRQ_CLR;
    wire wr_load_lo = bus_req.wr && bus_req.addr == OFF_LO_LOAD;
    wire wr_load_hi = bus_req.wr && bus_req.addr == OFF_HI_LOAD;
    wire wr_match   = bus_req.wr && bus_req.addr == OFF_LO_MATCH;
    wire wr_pre_lo  = bus_req.wr && bus_req.addr == OFF_LO_PRE;
    wire wr_pre_hi  = bus_req.wr && bus_req.addr == OFF_HI_PRE;

    // R4 mode select
    wire mode32 = cfg_q == CFG_32_TIMER;
    wire rtc    = cfg_q == CFG_32_RTC;
    // R23 split select
    wire m16    = cfg_q == CFG_16_SPLIT;

    // R1 halves joined
    wire [31:0] cnt32  = {cnt_hi_q, cnt_lo_q};
    wire [31:0] load32 = {load_hi_q, load_lo_q};
    wire        lo_en  = ctl_q[CTL_LO_EN];
    wire        hi_en  = ctl_q[CTL_HI_EN];

    // R15 debug stall
    wire stall_lo = dbg_halt && ctl_q[CTL_LO_STALL];
    wire stall_hi = dbg_halt && ctl_q[CTL_HI_STALL];
    wire run32    = mode32 && lo_en && !stall_lo;
    wire run_lo16 = m16 && lo_en && !stall_lo;
    wire run_hi16 = m16 && hi_en && !stall_hi;

    // R22 RTC enable overrides stall
    wire rtc_hold = dbg_halt && (ctl_q[CTL_LO_STALL] || ctl_q[CTL_HI_STALL]);
    wire rtc_run  = rtc && lo_en && (ctl_q[CTL_RTC_EN] || !rtc_hold);

    wire zero32  = run32 && cnt32 == 32'h0000_0000;
    wire zero_lo = run_lo16 && cnt_lo_q == 16'h0000;
    wire zero_hi = run_hi16 && cnt_hi_q == 16'h0000;
    // R8 low field only
    wire lo_oneshot = lo_mode_q == MODE_ONESHOT;
    // R5 independent halves
    wire hi_oneshot = hi_mode_q == MODE_ONESHOT;
    wire to_lo = zero32 || zero_lo;
    wire to_hi = zero_hi;

    // R25 sync and edge
    wire cap_rise = cap_s2_q && !cap_s3_q;
    // R18 divide to tick
    wire div_end  = div_q == DIV_W'(RTC_DIV - 1);
    wire rtc_step = rtc_run && cap_rise && div_end;
    wire rtc_match = rtc_step && cnt32 == match_q;
    // R16 seed once
    wire seed_rtc = wr_cfg && bus_req.wdata[2:0] == CFG_32_RTC && !rtc_seen_q;
    // R24 masked status
    wire [15:0] mis = ris_q & imr_q;

    always_comb begin
        cnt_d = cnt32;
        if (seed_rtc) begin
            cnt_d = RTC_SEED;
        end else if (rtc) begin
            // R19 wrap on match
            if (rtc_step) begin
                cnt_d = rtc_match ? 32'h0000_0000 : cnt32 + 32'h0000_0001;
            end
        end else if (mode32) begin
            // R14 load while running
            if (wr_load_lo) begin
                cnt_d = bus_req.wdata;
            // R9 reload at zero
            end else if (zero32) begin
                cnt_d = load32;
            end else if (run32) begin
                cnt_d = cnt32 - 32'h0000_0001;
            end
        end else if (m16) begin
            // R5 low half alone
            if (wr_load_lo) begin
                cnt_d[15:0] = bus_req.wdata[15:0];
            end else if (zero_lo) begin
                cnt_d[15:0] = load_lo_q;
            end else if (run_lo16) begin
                cnt_d[15:0] = cnt_lo_q - 16'h0001;
            end
            if (wr_load_hi) begin
                cnt_d[31:16] = bus_req.wdata[15:0];
            end else if (zero_hi) begin
                cnt_d[31:16] = load_hi_q;
            end else if (run_hi16) begin
                cnt_d[31:16] = cnt_hi_q - 16'h0001;
            end
        end
    end

    // Software writes to the control register win over a one-shot clear in
    // the same cycle, so a fresh start is never swallowed.
    always_comb begin
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d = bus_req.wdata[15:0];
        end else begin
            // R10 one-shot stop
            if ((zero32 || zero_lo) && lo_oneshot) begin
                ctl_d[CTL_LO_EN] = 1'b0;
            end
            if (zero_hi && hi_oneshot) begin
                ctl_d[CTL_HI_EN] = 1'b0;
            end
        end
    end

    // R11 sticky timeout, set wins
    // R21 clear RTC status
    always_comb begin
        ris_d = ris_q;
        if (wr_icr) begin
            ris_d = ris_q & ~bus_req.wdata[15:0];
        end
        if (to_lo) begin
            ris_d[RIS_TO_LO] = 1'b1;
        end
        if (to_hi) begin
            ris_d[RIS_TO_HI] = 1'b1;
        end
        // R20 match status
        if (rtc_match) begin
            ris_d[RIS_RTC] = 1'b1;
        end
    end

    // R7 joined count read
    always_comb begin
        unique case (bus_req.addr)
            OFF_CONFIG:   rd_val = {29'h0, cfg_q};
            OFF_LO_MODE:  rd_val = {30'h0, lo_mode_q};
            OFF_HI_MODE:  rd_val = {30'h0, hi_mode_q};
            OFF_CONTROL:  rd_val = {16'h0, ctl_q};
            OFF_IRQ_MASK: rd_val = {16'h0, imr_q};
            OFF_IRQ_RAW:  rd_val = {16'h0, ris_q};
            // R12 masked view
            OFF_IRQ_MSK:  rd_val = {16'h0, mis};
            OFF_LO_LOAD:  rd_val = m16 ? {16'h0, load_lo_q} : load32;
            OFF_HI_LOAD:  rd_val = {16'h0, load_hi_q};
            OFF_LO_MATCH: rd_val = match_q;
            OFF_LO_PRE:   rd_val = {24'h0, pre_lo_q};
            OFF_HI_PRE:   rd_val = {24'h0, pre_hi_q};
            OFF_LO_COUNT: rd_val = m16 ? {16'h0, cnt_lo_q} : cnt32;
            OFF_HI_COUNT: rd_val = {16'h0, cnt_hi_q};
            default:      rd_val = 32'h0000_0000;
        endcase
    end

    // R3 reset state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q     <= CFG_32_TIMER;
            lo_mode_q <= 2'h0;
            hi_mode_q <= 2'h0;
            ctl_q     <= 16'h0000;
            imr_q     <= 16'h0000;
            ris_q     <= 16'h0000;
            cnt_lo_q  <= CNT_RST;
            cnt_hi_q  <= CNT_RST;
            rdata     <= 32'h0000_0000;
        end else begin
            if (wr_cfg) begin
                cfg_q <= bus_req.wdata[2:0];
            end
            if (wr_lo_mode) begin
                lo_mode_q <= bus_req.wdata[1:0];
            end
            if (wr_hi_mode) begin
                hi_mode_q <= bus_req.wdata[1:0];
            end
            if (wr_imr) begin
                imr_q <= bus_req.wdata[15:0];
            end
            ctl_q    <= ctl_d;
            ris_q    <= ris_d;
            cnt_lo_q <= cnt_d[15:0];
            cnt_hi_q <= cnt_d[31:16];
            rdata    <= bus_req.rd ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            load_lo_q <= CNT_RST;
            load_hi_q <= CNT_RST;
            pre_lo_q  <= PRE_RST;
            pre_hi_q  <= PRE_RST;
            match_q   <= 32'h0000_0000;
        end else begin
            // R6 joined load write
            if (wr_load_lo) begin
                load_lo_q <= bus_req.wdata[15:0];
            end
            if (wr_load_lo && !m16) begin
                load_hi_q <= bus_req.wdata[31:16];
            end else if (wr_load_hi) begin
                load_hi_q <= bus_req.wdata[15:0];
            end
            if (wr_pre_lo) begin
                pre_lo_q <= bus_req.wdata[7:0];
            end
            if (wr_pre_hi) begin
                pre_hi_q <= bus_req.wdata[7:0];
            end
            if (wr_match) begin
                match_q <= bus_req.wdata;
            end
        end
    end

    // R25 input synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cap_s1_q <= 1'b0;
            cap_s2_q <= 1'b0;
            cap_s3_q <= 1'b0;
        end else begin
            cap_s1_q <= capture_pin_0;
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
        end
    end

    // The divider restarts whenever the RTC stops, so a new start always
    // waits one full second before the first step.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_q      <= '0;
            rtc_seen_q <= 1'b0;
        end else begin
            if (seed_rtc) begin
                rtc_seen_q <= 1'b1;
            end
            // R18 edge divider
            if (!rtc_run) begin
                div_q <= '0;
            end else if (cap_rise) begin
                div_q <= div_end ? '0 : div_q + DIV_W'(1);
            end
        end
    end

    // R13 gated trigger
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            adc_q <= 1'b0;
        end else begin
            adc_q <= (to_lo && ctl_q[CTL_LO_ADC]) || (to_hi && ctl_q[CTL_HI_ADC]);
        end
    end

    // R2 trigger chain OR
    assign adc_trigger_out = adc_q || adc_trigger_in;
    // R24 interrupt OR
    assign irq_out = |mis;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_zero32;
        run32 && cnt32 == 32'h0000_0000 && !wr_load_lo;
    endsequence
    sequence s_rd_cnt;
        bus_req.rd && bus_req.addr == OFF_LO_COUNT && !m16;
    endsequence

    property p_reload;
        s_zero32 ##0 !wr_load_hi |=> cnt32 == $past(load32);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload at zero"); // R9
    property p_count_down;
        run32 && cnt32 != 32'h0000_0000 && !wr_load_lo |=> cnt32 == $past(cnt32) - 32'h1;
    endproperty
    a_count_down: assert property (p_count_down) else $error("no decrement"); // R9
    property p_oneshot;
        s_zero32 ##0 (lo_oneshot && !wr_ctl) |=> !ctl_q[CTL_LO_EN];
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot kept running"); // R10
    property p_timeout;
        s_zero32 |=> ris_q[RIS_TO_LO] ##1 (ris_q[RIS_TO_LO] || $past(wr_icr));
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag lost"); // R11
    property p_irq;
        s_zero32 ##0 (imr_q[RIS_TO_LO] && !wr_imr) |=> irq_out && mis[RIS_TO_LO];
    endproperty
    a_irq: assert property (p_irq) else $error("masked timeout missing"); // R12
    property p_adc;
        to_lo && ctl_q[CTL_LO_ADC] |=> adc_trigger_out;
    endproperty
    a_adc: assert property (p_adc) else $error("trigger missing"); // R13
    property p_load32;
        wr_load_lo && mode32 |=> cnt32 == $past(bus_req.wdata) && load32 == $past(bus_req.wdata);
    endproperty
    a_load32: assert property (p_load32) else $error("joined load wrong"); // R14
    property p_stall;
        mode32 && lo_en && stall_lo && !wr_load_lo |=> $stable(cnt32);
    endproperty
    a_stall: assert property (p_stall) else $error("count moved in halt"); // R15
    property p_rtc_wrap;
        rtc_match |=> cnt32 == 32'h0000_0000 && ris_q[RIS_RTC];
    endproperty
    a_rtc_wrap: assert property (p_rtc_wrap) else $error("rtc did not wrap"); // R19
    property p_rtc_clr;
        wr_icr && bus_req.wdata[RIS_RTC] && !rtc_match |=> !ris_q[RIS_RTC] && !mis[RIS_RTC];
    endproperty
    a_rtc_clr: assert property (p_rtc_clr) else $error("rtc status not cleared"); // R21
    property p_rd_cnt;
        s_rd_cnt |=> rdata == $past(cnt32) ##1 (rdata == 32'h0 || $past(bus_req.rd));
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("joined count read wrong"); // R7
endmodule // gtm_timer

//--- bench/gtm_rtc_src.sv
// Purpose: Slow reference clock source for the real-time count input pin.
// Assumes: The bench holds run steady across whole periods.
// Notes:   The default half period suits a 32.768 kHz source; the bench shortens it.
`timescale 1ns/100ps
module gtm_rtc_src #(
    parameter int HALF_NS = 15259
) (
    // Control.
    input  wire logic run,
    // Clock pin.
    output logic      rtc_clk
);
    initial rtc_clk = 1'b0;

    // reference clock drive.
    // The clock parks low between runs so that no stray edge reaches the divider.
    always begin
        #(HALF_NS);
        rtc_clk = run ? ~rtc_clk : 1'b0;
    end
endmodule // gtm_rtc_src

//--- bench/tb.sv
// Purpose: Self-checking bench for the general timer block.
// Assumes: A short divider, so that the real-time count steps within a few hundred cycles.
// Notes:   A monitor scores reads against a queue of expected values.
`timescale 1ns/100ps
module tb;
    import gtm_pkg::*;

    localparam int DIV = 4;
    localparam int LIM = 1000;

    logic         clock;
    logic         rst_n;
    gtm_bus_req_s bus_req;
    logic [31:0]  rdata;
    logic         capture_pin_0;
    logic         dbg_halt;
    logic         adc_trigger_in;
    logic         adc_trigger_out;
    logic         irq_out;
    logic         rtc_run;
    logic         rd_d;
    logic [39:0]  ent;
    logic [39:0]  exp_q[$];
    logic [31:0]  rng;
    int           failures;
    int           total_checks;
    int           adc_cnt;
    int           cyc;

    gtm_timer #(.RTC_DIV(DIV), .DIV_W(16)) dut (
        .clock          (clock),
        .rst_n          (rst_n),
        .bus_req        (bus_req),
        .rdata          (rdata),
        .capture_pin_0  (capture_pin_0),
        .dbg_halt       (dbg_halt),
        .adc_trigger_in (adc_trigger_in),
        .adc_trigger_out(adc_trigger_out),
        .irq_out        (irq_out)
    );

    // The odd half period keeps the pin out of phase with the system clock.
    gtm_rtc_src #(.HALF_NS(41)) rtc_src (
        .run    (rtc_run),
        .rtc_clk(capture_pin_0)
    );

    initial clock = 1'b0;
    always #2.5 clock = ~clock;

    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        exp_q.push_back({a, e});
        @(posedge clock);
        bus_req <= '0;
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (irq_out !== 1'b1 && n < LIM);
        check("irq_out", 32'(irq_out), 32'h1);
    endtask

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // Read data stand only in the cycle after the strobe, so they are scored there.
    always @(posedge clock) rd_d <= bus_req.rd;
    always @(negedge clock) begin
        if (rd_d === 1'b1 && exp_q.size() > 0) begin
            ent = exp_q.pop_front();
            check($sformatf("reg %h", ent[39:32]), rdata, ent[31:0]);
        end
    end

    always @(posedge clock) begin
        if (adc_trigger_out === 1'b1 && adc_trigger_in === 1'b0) begin
            adc_cnt <= adc_cnt + 1;
        end
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        logic [31:0] v;
        int          a0;
        rng = 32'h62;
        failures = 0;
        total_checks = 0;
        adc_cnt = 0;
        cyc = 0;
        rd_d = 1'b0;
        bus_req = '0;
        dbg_halt = 1'b0;
        adc_trigger_in = 1'b0;
        rtc_run = 1'b0;
        rst_n = 1'b0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        rd(OFF_LO_LOAD, 32'hFFFF_FFFF);
        rd(OFF_HI_LOAD, 32'h0000_FFFF);
        rd(OFF_LO_COUNT, 32'hFFFF_FFFF);
        rd(OFF_HI_COUNT, 32'h0000_FFFF);
        rd(OFF_LO_PRE, 32'h0);
        rd(OFF_HI_PRE, 32'h0);
        rd(OFF_CONFIG, 32'h0);
        rd(OFF_CONTROL, 32'h0);
        rd(OFF_IRQ_MASK, 32'h0);
        rd(OFF_IRQ_RAW, 32'h0);
        rd(8'h10, 32'h0);
        @(posedge clock);
        adc_trigger_in <= 1'b1;
        @(negedge clock);
        check("adc_out", 32'(adc_trigger_out), 32'h1);
        @(posedge clock);
        adc_trigger_in <= 1'b0;
        v = xs();
        wr(OFF_LO_LOAD, v);
        rd(OFF_HI_LOAD, {16'h0, v[31:16]});
        rd(OFF_LO_COUNT, v);
        rd(OFF_HI_COUNT, {16'h0, v[31:16]});
        wr(OFF_IRQ_MASK, 32'h1);
        wr(OFF_HI_MODE, 32'(MODE_PERIODIC));
        wr(OFF_LO_MODE, 32'(MODE_ONESHOT));
        wr(OFF_LO_LOAD, 32'h3);
        a0 = adc_cnt;
        wr(OFF_CONTROL, 32'h21);
        wait_irq();
        rd(OFF_CONTROL, 32'h20);
        rd(OFF_LO_COUNT, 32'h3);
        rd(OFF_IRQ_RAW, 32'h1);
        rd(OFF_IRQ_MSK, 32'h1);
        check("adc pulses", 32'(adc_cnt - a0), 32'h1);
        wr(OFF_IRQ_MASK, 32'h0);
        @(negedge clock);
        check("irq masked", 32'(irq_out), 32'h0);
        rd(OFF_IRQ_RAW, 32'h1);
        rd(OFF_IRQ_MSK, 32'h0);
        wr(OFF_IRQ_CLR, 32'h1);
        rd(OFF_IRQ_RAW, 32'h0);
        wr(OFF_IRQ_MASK, 32'h1);
        wr(OFF_LO_MODE, 32'(MODE_PERIODIC));
        wr(OFF_HI_MODE, 32'(MODE_ONESHOT));
        wr(OFF_LO_LOAD, 32'h4);
        a0 = adc_cnt;
        wr(OFF_CONTROL, 32'h1);
        wait_irq();
        wr(OFF_IRQ_CLR, 32'h1);
        wait_irq();
        rd(OFF_CONTROL, 32'h1);
        check("adc off", 32'(adc_cnt - a0), 32'h0);
        wr(OFF_CONTROL, 32'h0);
        wr(OFF_IRQ_CLR, 32'h1);
        // stall freezes, load taken while enabled.
        dbg_halt <= 1'b1;
        wr(OFF_CONTROL, 32'h3);
        v = 32'h100 | (xs() & 32'hFF);
        wr(OFF_LO_LOAD, v);
        repeat (20) @(posedge clock);
        rd(OFF_LO_COUNT, v);
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_LO_LOAD, 32'h40);
        rd(OFF_LO_COUNT, 32'h3F);
        wait_irq();
        dbg_halt <= 1'b0;
        wr(OFF_CONTROL, 32'h0);
        wr(OFF_IRQ_CLR, 32'h1);
        // real-time count with wrap at match.
        wr(OFF_CONFIG, 32'(CFG_32_RTC));
        rd(OFF_LO_COUNT, RTC_SEED);
        wr(OFF_LO_MATCH, 32'h2);
        rd(OFF_LO_MATCH, 32'h2);
        wr(OFF_IRQ_MASK, 32'h8);
        dbg_halt <= 1'b1;
        wr(OFF_CONTROL, 32'h13);
        rtc_run <= 1'b1;
        wait_irq();
        rd(OFF_LO_COUNT, 32'h0);
        rd(OFF_IRQ_RAW, 32'h8);
        rd(OFF_IRQ_MSK, 32'h8);
        wr(OFF_IRQ_CLR, 32'h8);
        rd(OFF_IRQ_RAW, 32'h0);
        rd(OFF_IRQ_MSK, 32'h0);
        rtc_run <= 1'b0;
        dbg_halt <= 1'b0;
        wr(OFF_CONTROL, 32'h0);
        // split halves run on their own settings.
        wr(OFF_CONFIG, 32'(CFG_16_SPLIT));
        wr(OFF_LO_LOAD, 32'hAAAA_5555);
        rd(OFF_LO_LOAD, 32'h0000_5555);
        rd(OFF_HI_LOAD, 32'h0);
        wr(OFF_LO_LOAD, 32'h3);
        wr(OFF_HI_MODE, 32'(MODE_ONESHOT));
        wr(OFF_HI_LOAD, 32'h2);
        wr(OFF_IRQ_MASK, 32'h100);
        a0 = adc_cnt;
        wr(OFF_CONTROL, 32'h2101);
        wait_irq();
        rd(OFF_CONTROL, 32'h2001);
        rd(OFF_IRQ_RAW, 32'h101);
        check("adc hi", 32'(adc_cnt - a0), 32'h1);
        repeat (4) @(posedge clock);
        stop_test();
    end
endmodule // tb
